// >>> inc/scc_pkg.sv
/*
 Constants, register map and mode codes of the serial channel control block.
 Assumes a 16-bit register port with word addresses spaced by four.
*/
package scc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [4:0]  ADDR_CTRL = 5'h00;
   localparam logic [4:0]  ADDR_BAUD = 5'h04;
   localparam logic [4:0]  ADDR_FDIV = 5'h08;
   localparam logic [4:0]  ADDR_TXD  = 5'h0c;
   localparam logic [4:0]  ADDR_RXD  = 5'h10;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int BIT_RUN  = 15;
   localparam int BIT_LOOP = 14;
   localparam int BIT_PRE3 = 13;
   localparam int BIT_ODD  = 12;
   localparam int BIT_FRAC = 11;
   localparam int BIT_OVR  = 10;
   localparam int BIT_FRM  = 9;
   localparam int BIT_PAR  = 8;
   localparam int BIT_OVEN = 7;
   localparam int BIT_FREN = 6;
   localparam int BIT_PEN  = 5;
   localparam int BIT_REN  = 4;
   localparam int BIT_STP  = 3;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'hf8ff;
   localparam logic [15:0] FLAG_MASK  = 16'h0700;
   localparam int RXD_FULL_BIT = 15;
   localparam int TXD_PEND_BIT = 15;
   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int BAUD_W  = 13;
   localparam int FDIV_W  = 9;
   localparam int DATA_W  = 9;
   localparam int FRAME_W = 13;
   localparam logic [3:0]  FRAME_LEN_MAX = 4'hd;
   localparam logic [3:0]  SYNC_LEN      = 4'h8;
   localparam logic [1:0]  PRE2_LAST     = 2'h1;
   localparam logic [1:0]  PRE3_LAST     = 2'h2;
   // ----------------------------------------------------------------
   // Frame layouts and shifter states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SYNC8 = 3'h0,
      MODE_ASY8  = 3'h1,
      MODE_IRDA8 = 3'h2,
      MODE_7P    = 3'h3,
      MODE_9     = 3'h4,
      MODE_8W    = 3'h5,
      MODE_RSVD  = 3'h6,
      MODE_8P    = 3'h7
   } scc_mode_t;
   typedef enum logic {
      ST_IDLE  = 1'b0,
      ST_SHIFT = 1'b1
   } scc_st_t;
endpackage : scc_pkg

// >>> verilog/scc_serial_channel_control.sv
/*
 Serial channel control: control register, prescaler, baud timer, a plain
 bit-rate transmitter and receiver, and the error flags.
 Assumes the register port master of the house style and a line that is
 synchronous to clk; one line sample per bit time, no oversampling.
*/
// What this block does
// - Run bit low halts baud generator and channel
// - Loopback bit routes transmit line to receiver
// - Prescaler bit picks divide by two or three
// - Fractional divider replaces prescaler when enabled
// - Odd bit inverts the generated parity sense
// - Overrun sets sticky flag while check enabled
// - Framing error sets sticky flag while enabled
// - Parity error sets sticky flag while enabled
// - Overrun check enable gates overrun detection
// - Framing check enable, asynchronous frames only
// - Bit five enables parity check outside infrared
// - Bit five inverts receive input in infrared
// - Receiver enable, self clearing after synchronous byte
// - Stop bit count selects one or two
// - Layout 000 is eight bit synchronous
// - Layouts 001, 010 are eight bit; 010 is infrared
// - Layouts 011, 111 add a parity bit
// - Layouts 100, 101 carry nine bits
// - Baud reload register holds thirteen bits
// - Low expected stop bit is a framing error
// - Parity mismatch on received frame is an error
`timescale 1ns/1ps
`default_nettype none
module scc_serial_channel_control
   import scc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Serial line
   input  wire logic        rx_line,
   output logic             tx_line
);
   // ----------------------------------------------------------------
   // Layout decoding
   // ----------------------------------------------------------------
   function automatic logic has_par(input scc_mode_t m);
      has_par = (m == MODE_7P) || (m == MODE_8P);
   endfunction : has_par

   function automatic logic [3:0] frame_len(input scc_mode_t m, input logic two);
      logic [3:0] nd;
      nd = (m == MODE_7P) ? 4'h7 : ((m == MODE_9) || (m == MODE_8W)) ? 4'h9 : 4'h8;
      if (m == MODE_SYNC8) begin
         frame_len = SYNC_LEN;
      end else begin
         frame_len = 4'h2 + nd + {3'h0, has_par(m)} + {3'h0, two};
      end
   endfunction : frame_len

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0]        ctrl;
   logic [15:0]        next_ctrl;
   logic [BAUD_W-1:0]  baud_reload;
   logic [BAUD_W-1:0]  baud_cnt;
   logic [FDIV_W-1:0]  fdiv;
   logic [FDIV_W-1:0]  frac_acc;
   logic [1:0]         pre_cnt;
   scc_st_t            tx_st;
   logic               tx_pend;
   logic [DATA_W-1:0]  tx_buf;
   logic [FRAME_W-1:0] tx_sh;
   logic [3:0]         tx_cnt;
   scc_st_t            rx_st;
   logic [FRAME_W-1:0] rx_sh;
   logic [3:0]         rx_cnt;
   logic               rx_done;
   logic               rx_full;
   logic [DATA_W-1:0]  rx_buf;

   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   scc_mode_t mode;
   wire run      = ctrl[BIT_RUN];
   wire loop     = ctrl[BIT_LOOP];
   wire pre3     = ctrl[BIT_PRE3];
   wire odd      = ctrl[BIT_ODD];
   wire frac     = ctrl[BIT_FRAC];
   wire ren      = ctrl[BIT_REN];
   wire stop_bit_count      = ctrl[BIT_STP];
   assign mode   = scc_mode_t'(ctrl[2:0]);
   wire sync     = (mode == MODE_SYNC8);
   wire irda     = (mode == MODE_IRDA8);
   wire [3:0] flen = frame_len(mode, stop_bit_count);
   wire wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
   wire wr_baud  = reg_wr && (reg_addr == ADDR_BAUD);
   wire wr_fdiv  = reg_wr && (reg_addr == ADDR_FDIV);
   wire wr_txd   = reg_wr && (reg_addr == ADDR_TXD);
   wire rd_rxd   = reg_rd && (reg_addr == ADDR_RXD);

   // ----------------------------------------------------------------
   // Prescaler and baud timer
   // ----------------------------------------------------------------
   wire [FDIV_W:0] frac_sum = {1'b0, frac_acc} + {1'b0, fdiv};
   // At or past the end, so a switch from three to two never skips a wrap
   wire pre_last = (pre_cnt >= (pre3 ? PRE3_LAST : PRE2_LAST));
   // A zero fraction passes the clock straight through
   wire frac_en  = (fdiv == '0) || frac_sum[FDIV_W];
   wire pre_en   = run && (frac ? frac_en : pre_last);
   wire tick     = pre_en && (baud_cnt == '0);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_cnt  <= 2'h0;
         frac_acc <= '0;
         baud_cnt <= '0;
      end else if (!run) begin
         pre_cnt  <= 2'h0;
         frac_acc <= '0;
         baud_cnt <= baud_reload;
      end else begin
         pre_cnt  <= pre_last ? 2'h0 : pre_cnt + 2'h1;
         frac_acc <= frac_sum[FDIV_W-1:0];
         if (pre_en) begin
            baud_cnt <= (baud_cnt == '0) ? baud_reload : baud_cnt - 13'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   wire tx_par = odd ^ ((mode == MODE_7P) ? ^tx_buf[6:0] : ^tx_buf[7:0]);
   wire [8:0] tx_pay =
      (mode == MODE_7P) ? {1'b1, tx_par, tx_buf[6:0]} :
      (mode == MODE_8P) ? {tx_par, tx_buf[7:0]} :
      ((mode == MODE_9) || (mode == MODE_8W)) ? tx_buf : {1'b1, tx_buf[7:0]};
   // Unused upper frame bits are ones, so stop bits come for free
   wire [FRAME_W-1:0] tx_frame = sync ? {5'h1f, tx_buf[7:0]} : {3'h7, tx_pay, 1'b0};
   wire tx_start = tick && (tx_st == ST_IDLE) && tx_pend;
   wire tx_end   = tick && (tx_st == ST_SHIFT) && (tx_cnt == flen);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_st   <= ST_IDLE;
         tx_sh   <= '1;
         tx_cnt  <= 4'h0;
         tx_line <= 1'b1;
      end else if (!run) begin
         tx_st   <= ST_IDLE;
         tx_line <= 1'b1;
      end else if (tx_start) begin
         tx_st   <= ST_SHIFT;
         tx_line <= tx_frame[0];
         tx_sh   <= {1'b1, tx_frame[FRAME_W-1:1]};
         tx_cnt  <= 4'h1;
      end else if (tx_end) begin
         tx_st   <= ST_IDLE;
         tx_line <= 1'b1;
      end else if (tick && (tx_st == ST_SHIFT)) begin
         tx_line <= tx_sh[0];
         tx_sh   <= {1'b1, tx_sh[FRAME_W-1:1]};
         tx_cnt  <= tx_cnt + 4'h1;
      end
   end

   // New data while pending overwrites the waiting word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_pend <= 1'b0;
         tx_buf  <= '0;
      end else if (wr_txd) begin
         tx_pend <= 1'b1;
         tx_buf  <= reg_wdata[DATA_W-1:0];
      end else if (tx_start) begin
         tx_pend <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   wire rx_raw = loop ? tx_line : rx_line;
   wire rx_in  = rx_raw ^ (irda && ctrl[BIT_PEN]);
   wire rx_go  = tick && (rx_st == ST_IDLE) && ren && (sync || !rx_in);
   wire rx_last = (rx_cnt + 4'h1) == flen;
   wire [FRAME_W-1:0] rx_al = rx_sh >> (FRAME_LEN_MAX - flen);
   wire [8:0] rx_pay  = rx_al[9:1];
   wire wide9 = (mode == MODE_9) || (mode == MODE_8W) || (mode == MODE_8P);
   wire [DATA_W-1:0] rx_data = sync ? {1'b0, rx_al[7:0]} :
                               wide9 ? rx_pay : {1'b0, rx_pay[7:0]};
   wire frame_bad = !rx_al[flen - 4'h1] || (stop_bit_count && !rx_al[flen - 4'h2]);
   wire par_rcv  = (mode == MODE_7P) ? rx_al[8] : rx_al[9];
   wire par_calc = odd ^ ((mode == MODE_7P) ? ^rx_al[7:1] : ^rx_al[8:1]);
   wire ovr_ev = rx_done && rx_full && ctrl[BIT_OVEN];
   wire frm_ev = rx_done && !sync && ctrl[BIT_FREN] && frame_bad;
   wire par_ev = rx_done && has_par(mode) && ctrl[BIT_PEN] && (par_rcv != par_calc);
   wire ren_clr = rx_done && sync;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_st   <= ST_IDLE;
         rx_sh   <= '0;
         rx_cnt  <= 4'h0;
         rx_done <= 1'b0;
      end else if (!run) begin
         rx_st   <= ST_IDLE;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (rx_go || (tick && (rx_st == ST_SHIFT))) begin
            rx_sh  <= {rx_in, rx_sh[FRAME_W-1:1]};
            rx_cnt <= rx_go ? 4'h1 : rx_cnt + 4'h1;
            rx_st  <= ST_SHIFT;
            if (rx_st == ST_SHIFT && rx_last) begin
               rx_st   <= ST_IDLE;
               rx_done <= 1'b1;
            end
         end
      end
   end

   // A new frame beats a read in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_full <= 1'b0;
         rx_buf  <= '0;
      end else if (rx_done) begin
         rx_full <= 1'b1;
         rx_buf  <= rx_data;
      end else if (rd_rxd) begin
         rx_full <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = (reg_wdata & CTRL_WMASK) | (ctrl & reg_wdata & FLAG_MASK);
      end else if (ren_clr) begin
         next_ctrl[BIT_REN] = 1'b0;
      end
      if (ovr_ev) begin
         next_ctrl[BIT_OVR] = 1'b1;
      end
      if (frm_ev) begin
         next_ctrl[BIT_FRM] = 1'b1;
      end
      if (par_ev) begin
         next_ctrl[BIT_PAR] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl        <= CTRL_RESET;
         baud_reload <= '0;
         fdiv        <= '0;
      end else begin
         ctrl <= next_ctrl;
         if (wr_baud) begin
            baud_reload <= reg_wdata[BAUD_W-1:0];
         end
         if (wr_fdiv) begin
            fdiv <= reg_wdata[FDIV_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   wire [15:0] rd_mux =
      (reg_addr == ADDR_CTRL) ? ctrl :
      (reg_addr == ADDR_BAUD) ? {3'h0, baud_reload} :
      (reg_addr == ADDR_FDIV) ? {7'h0, fdiv} :
      (reg_addr == ADDR_TXD)  ? {tx_pend, 6'h0, tx_buf} :
      (reg_addr == ADDR_RXD)  ? {rx_full, 6'h0, rx_buf} : 16'h0000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   run_off_a: assert property (!run |=> tx_line && rx_st == ST_IDLE && !rx_done)
      else $error("channel active while stopped");
   loop_start_a: assert property (loop && !tx_line && tick && rx_st == ST_IDLE
      && ren && !sync && !(irda && ctrl[BIT_PEN]) |=> rx_st == ST_SHIFT)
      else $error("loopback start bit missed");
   div_two_a: assert property (run && !frac && !pre3 && $past(run && !frac && !pre3)
      |-> pre_en != $past(pre_en))
      else $error("divide by two broken");
   div_three_a: assert property (run && !frac && pre3 && pre_en ##1 (run && !frac && pre3)
      ##1 (run && !frac && pre3) |-> !pre_en && !$past(pre_en))
      else $error("divide by three broken");
   frac_pass_a: assert property (run && frac && fdiv == '0 && baud_cnt != '0
      |=> baud_cnt == $past(baud_cnt) - 13'h1)
      else $error("fraction zero must pass through");
   tx_parity_a: assert property (tx_start && mode == MODE_8P
      |=> tx_sh[8] == ($past(odd) ^ ^$past(tx_buf[7:0])))
      else $error("transmit parity wrong");
   ovr_set_a: assert property (ovr_ev |=> ctrl[BIT_OVR])
      else $error("overrun flag not set");
   frm_set_a: assert property (frm_ev |=> ctrl[BIT_FRM])
      else $error("framing flag not set");
   par_set_a: assert property (par_ev |=> ctrl[BIT_PAR])
      else $error("parity flag not set");
   ovr_ignore_a: assert property (!ctrl[BIT_OVEN] && !ctrl[BIT_OVR] && !wr_ctrl
      |=> !ctrl[BIT_OVR])
      else $error("overrun flagged while ignored");
   sync_frm_a: assert property (sync && rx_done && !ctrl[BIT_FRM] && !wr_ctrl
      |=> !ctrl[BIT_FRM])
      else $error("framing error in synchronous mode");
   ren_clear_a: assert property (rx_done && sync && !wr_ctrl |=> !ren)
      else $error("receiver enable not cleared");
   flag_clear_a: assert property (wr_ctrl && !reg_wdata[BIT_PAR] && !par_ev
      |=> !ctrl[BIT_PAR])
      else $error("parity flag not cleared");

   rx_async_c: cover property (rx_done && !sync);
   rx_sync_c:  cover property (rx_done && sync);
   par_err_c:  cover property (par_ev);
   loop_tx_c:  cover property (tx_start && loop);
endmodule : scc_serial_channel_control
`default_nettype wire

// >>> verif/scc_line_model.sv
/*
 Remote transceiver model: drives the receive line with whole frames and
 samples frames from the transmit line.
 Assumes one clock; the caller gives the bit period in clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_line_model (
   // Clock
   input  wire logic clk,
   // Serial line
   input  wire logic tx_line,
   output logic      rx_line
);
   // ----------------------------------------------------------------
   // Frame driver and sampler
   // ----------------------------------------------------------------
   initial rx_line = 1'b1;
   // Idle level stands in for the line's pull state
   task automatic set_idle(input logic lvl);
      @(posedge clk);
      rx_line <= lvl;
   endtask : set_idle
   // LSB first; each bit held exactly one bit time, so any tick phase works
   task automatic send(input logic [12:0] bits, input int n, input int b,
                       input logic lvl);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_line <= bits[i];
         repeat (b - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= lvl;
      repeat (3 * b) @(posedge clk);
   endtask : send
   // Samples mid-bit from the falling start edge, LSB first
   task automatic recv(input int n, input int b, output logic [12:0] bits);
      bits = '0;
      while (tx_line !== 1'b0) @(posedge clk);
      repeat (b / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = tx_line;
         repeat (b) @(posedge clk);
      end
   endtask : recv
endmodule : scc_line_model
`default_nettype wire

// >>> verif/serial_channel_control_test.sv
/*
 Self-checking bench of the serial channel control block.
 Assumes scc_pkg and the line model; bit time is 8 or 12 clocks throughout.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_channel_control_test;
   import scc_pkg::*;
   logic        clk, sys_rst, reg_wr, reg_rd, rx_line, tx_line;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   int          bad_count, cmp_count, cyc;

   scc_serial_channel_control u_scc_serial_channel_control (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_line(rx_line), .tx_line(tx_line));
   scc_line_model u_scc_line_model (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run needs well under this; a hang ends here
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Bus and check helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Poll until bit k of a register equals v, bounded
   task automatic poll(input logic [4:0] a, input int k, input logic v,
                       output logic [15:0] d);
      rd(a, d);
      for (int i = 0; i < 400 && d[k] !== v; i++) rd(a, d);
   endtask : poll
   // Count samples while tx_line holds lvl
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (tx_line === lvl && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : run_len
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [15:0] d;
      rd(ADDR_CTRL, d);
      chk("ctrl reset", 16'h0000, d);
      wr(ADDR_CTRL, 16'hffff);
      rd(ADDR_CTRL, d);
      chk("ctrl flags", 16'hf8ff, d);
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_BAUD, 16'hffff);
      rd(ADDR_BAUD, d);
      chk("baud width", 16'h1fff, d);
      rd(5'h14, d);
      chk("unmapped", 16'h0000, d);
      $display("regs done");
   endtask : t_regs
   task automatic t_run();
      int n;
      wr(ADDR_BAUD, 16'h0003);
      wr(ADDR_CTRL, 16'h0001);
      wr(ADDR_TXD, 16'h00ff);
      run_len(1'b1, n);
      chk("halted", 16'h0bb8, 16'(n));
      wr(ADDR_CTRL, 16'h8001);
      run_len(1'b1, n);
      chk("started", 16'h0001, {15'h0000, n < 3000});
      repeat (100) @(posedge clk);
      $display("run done");
   endtask : t_run
   task automatic t_tx();
      logic [15:0] cfg [3] = '{16'h8001, 16'ha009, 16'ha801};
      logic [15:0] bw [3]  = '{16'h0008, 16'h000c, 16'h0008};
      logic [15:0] gw [3]  = '{16'h0050, 16'h0084, 16'h0050};
      int nl, nh;
      logic [12:0] fr;
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CTRL, 16'h0000);
         wr(ADDR_BAUD, 16'h0003);
         wr(ADDR_FDIV, 16'h0100);
         wr(ADDR_CTRL, cfg[k]);
         wr(ADDR_TXD, 16'h00ff);
         run_len(1'b1, nl);
         fork
            wr(ADDR_TXD, 16'h00ff);
            begin
               run_len(1'b0, nl);
               run_len(1'b1, nh);
            end
         join
         chk("start width", bw[k], 16'(nl));
         chk("frame gap", gw[k], 16'(nh));
         repeat (160) @(posedge clk);
      end
      wr(ADDR_CTRL, 16'h8007);
      fork
         wr(ADDR_TXD, 16'h0052);
         u_scc_line_model.recv(11, 8, fr);
      join
      chk("tx frame", 16'h06a4, {3'h0, fr});
      $display("tx done");
   endtask : t_tx
   task automatic t_loop();
      logic [15:0] cfg [4] = '{16'hd037, 16'hc037, 16'hc033, 16'hc014};
      logic [15:0] txd [4] = '{16'h00a5, 16'h00a5, 16'h0025, 16'h01a5};
      logic [15:0] ex [4]  = '{16'h81a5, 16'h80a5, 16'h80a5, 16'h81a5};
      logic [15:0] d;
      wr(ADDR_CTRL, 16'h0000);
      u_scc_line_model.set_idle(1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL, cfg[k]);
         wr(ADDR_TXD, txd[k]);
         poll(ADDR_RXD, 15, 1'b1, d);
         chk("loop data", ex[k], d & 16'h81ff);
         rd(ADDR_CTRL, d);
         chk("loop flags", 16'h0000, d & FLAG_MASK);
      end
      wr(ADDR_CTRL, 16'h0000);
      u_scc_line_model.set_idle(1'b1);
      $display("loopback done");
   endtask : t_loop
   task automatic t_errs();
      logic [15:0] d;
      wr(ADDR_CTRL, 16'h80f7);
      u_scc_line_model.send(13'h0200, 11, 8, 1'b1);
      rd(ADDR_CTRL, d);
      chk("err flags", 16'h83f7, d);
      rd(ADDR_RXD, d);
      wr(ADDR_CTRL, 16'h80f7);
      rd(ADDR_CTRL, d);
      chk("flags clear", 16'h80f7, d);
      u_scc_line_model.send(13'h0400, 11, 8, 1'b1);
      u_scc_line_model.send(13'h0400, 11, 8, 1'b1);
      rd(ADDR_CTRL, d);
      chk("overrun", 16'h84f7, d);
      rd(ADDR_RXD, d);
      wr(ADDR_CTRL, 16'h8017);
      u_scc_line_model.send(13'h0200, 11, 8, 1'b1);
      u_scc_line_model.send(13'h0200, 11, 8, 1'b1);
      rd(ADDR_CTRL, d);
      chk("checks off", 16'h8017, d);
      wr(ADDR_CTRL, 16'h0000);
      rd(ADDR_RXD, d);
      $display("errors done");
   endtask : t_errs
   task automatic t_sync();
      logic [15:0] d;
      u_scc_line_model.set_idle(1'b0);
      wr(ADDR_CTRL, 16'h8050);
      poll(ADDR_CTRL, 4, 1'b0, d);
      chk("rx en clear", 16'h8040, d);
      rd(ADDR_RXD, d);
      chk("sync data", 16'h8000, d & 16'h80ff);
      u_scc_line_model.set_idle(1'b1);
      $display("sync done");
   endtask : t_sync
   task automatic t_irda();
      logic [15:0] d;
      wr(ADDR_CTRL, 16'h0000);
      u_scc_line_model.set_idle(1'b0);
      wr(ADDR_CTRL, 16'h8032);
      u_scc_line_model.send(~13'h0278, 10, 8, 1'b0);
      rd(ADDR_RXD, d);
      chk("irda data", 16'h803c, d & 16'h81ff);
      wr(ADDR_CTRL, 16'h0000);
      u_scc_line_model.set_idle(1'b1);
      $display("irda done");
   endtask : t_irda
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   // Layout 110 is never programmed anywhere here
   initial begin
      sys_rst   = 1'b1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 5'h00;
      reg_wdata = 16'h0000;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_run();
      t_tx();
      t_loop();
      t_errs();
      t_sync();
      t_irda();
      end_of_test();
   end
endmodule : serial_channel_control_test
`default_nettype wire
